// ==== rtl/urs_defines.vh ====
// register map, field positions, reset values and sizes of the serial status block
`ifndef URS_DEFINES_VH
`define URS_DEFINES_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define URS_OFS_DATA        12'h000
`define URS_OFS_ERR         12'h004
`define URS_OFS_FLAGS       12'h018
`define URS_OFS_BAUD        12'h024
`define URS_OFS_LINE        12'h02C
`define URS_OFS_CTRL        12'h030

// ----------------------------------------------------------------------
// line_control fields
// ----------------------------------------------------------------------
`define URS_LC_PEN          1
`define URS_LC_EPS          2
`define URS_LC_STP2         3
`define URS_LC_FIFO_ON      4
`define URS_LC_WLEN_LO      5
`define URS_LC_SPS          7

// ----------------------------------------------------------------------
// control fields and reset values
// ----------------------------------------------------------------------
`define URS_CR_EN           0
`define URS_CR_TXE          8
`define URS_CR_RXE          9
`define URS_CR_RST          16'h0300
`define URS_LC_RST          8'h00
`define URS_BAUD_RST        16'h0000
`define URS_ERR_RST         4'h0

// ----------------------------------------------------------------------
// error bit positions inside receive_error_status
// ----------------------------------------------------------------------
`define URS_ERR_FRAME       0
`define URS_ERR_PARITY      1
`define URS_ERR_BREAK       2
`define URS_ERR_OE          3

// ----------------------------------------------------------------------
// buffer sizes
// ----------------------------------------------------------------------
`define URS_FIFO_DEPTH      5'd16
`define URS_HOLD_DEPTH      5'd1
`define URS_RX_WIDTH        12

`endif

// ==== rtl/urs_sync3.v ====
// three-stage input synchroniser that passes a level once two stages agree
module urs_sync3 #(
    parameter RST_VAL = 1'b1
) (
    input  wire clk_sys_i,
    input  wire sys_rst_i,
    input  wire async_i,
    output reg  level_o
);

    reg q1;
    reg q2;
    reg q3;

    // q1 feeds q2 only, to keep metastability off the compare
    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            q1      <= RST_VAL;
            q2      <= RST_VAL;
            q3      <= RST_VAL;
            level_o <= RST_VAL;
        end else begin
            q1 <= async_i;
            q2 <= q1;
            q3 <= q2;
            if (q2 == q3) begin
                level_o <= q3;
            end
        end
    end

endmodule // urs_sync3

// ==== rtl/urs_top.v ====
// serial port with receive error status, error clear alias and line flags
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`include "urs_defines.vh"

module urs_top (
    input  wire        clk_sys_i,
    input  wire        sys_rst_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    input  wire        rx_i,
    output reg         tx_o,
    input  wire        ring_in_n_i,
    input  wire        carrier_in_n_i,
    input  wire        peer_ready_in_n_i,
    input  wire        send_permit_in_n_i
);

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    wire rx_s;
    wire ring_s;
    wire carrier_s;
    wire peer_s;
    wire permit_s;

    urs_sync3 #(.RST_VAL(1'b1)) u_rx (.clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i), .async_i(rx_i), .level_o(rx_s));
    urs_sync3 #(.RST_VAL(1'b1)) u_ring (.clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i), .async_i(ring_in_n_i), .level_o(ring_s));
    urs_sync3 #(.RST_VAL(1'b1)) u_carrier (.clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i), .async_i(carrier_in_n_i),
        .level_o(carrier_s));
    urs_sync3 #(.RST_VAL(1'b1)) u_dsr (.clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i), .async_i(peer_ready_in_n_i),
        .level_o(peer_s));
    urs_sync3 #(.RST_VAL(1'b1)) u_cts (.clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i), .async_i(send_permit_in_n_i),
        .level_o(permit_s));

    // ------------------------------------------------------------------
    // software registers and decode
    // ------------------------------------------------------------------
    reg  [15:0] baud_div;
    reg  [7:0]  line_control;
    reg  [15:0] ctrl;
    reg  [3:0]  receive_error_status;
    reg         rd_ok;

    wire        fifo_on   = line_control[`URS_LC_FIFO_ON];
    wire [4:0]  depth     = fifo_on ? `URS_FIFO_DEPTH : `URS_HOLD_DEPTH;
    wire [3:0]  nbits     = 4'd5 + {2'b00, line_control[6:5]};
    wire        pen       = line_control[`URS_LC_PEN];
    wire        eps       = line_control[`URS_LC_EPS];
    wire        sps       = line_control[`URS_LC_SPS];
    // a zero divisor would stall the timers, so it runs as one
    wire [15:0] div_eff   = (baud_div == 16'h0000) ? 16'h0001 : baud_div;
    wire [19:0] bit_len   = {div_eff, 4'h0};
    wire [19:0] half_len  = {1'b0, bit_len[19:1]};
    wire        access    = psel_i & penable_i & pready_o;
    wire        hit_data  = (paddr_i == `URS_OFS_DATA);
    wire        hit_err   = (paddr_i == `URS_OFS_ERR);
    wire        hit_flags = (paddr_i == `URS_OFS_FLAGS);
    wire        hit_baud  = (paddr_i == `URS_OFS_BAUD);
    wire        hit_line  = (paddr_i == `URS_OFS_LINE);
    wire        hit_ctrl  = (paddr_i == `URS_OFS_CTRL);
    wire        mapped    = hit_data | hit_err | hit_flags | hit_baud |
                            hit_line | hit_ctrl;

    // ------------------------------------------------------------------
    // receive fifo (holding register is its bottom word)
    // ------------------------------------------------------------------
    reg  [`URS_RX_WIDTH-1:0] rx_mem [0:15];
    reg  [3:0]  rx_wp;
    reg  [3:0]  rx_rp;
    reg  [4:0]  rx_cnt;
    reg         rx_push;
    reg  [`URS_RX_WIDTH-1:0] rx_word;
    reg         ov_pend;

    wire rx_full  = (rx_cnt >= depth);
    wire rx_empty = (rx_cnt == 5'd0);
    wire rx_pop   = access & ~pwrite_i & hit_data & rd_ok;
    wire rx_wr    = rx_push & ~rx_full;
    wire overrun  = rx_push & rx_full;
    wire [`URS_RX_WIDTH-1:0] rx_top = rx_mem[rx_rp];

    always @(posedge clk_sys_i) begin
        if (rx_wr) begin
            rx_mem[rx_wp] <= rx_word;
        end
    end

    // a full fifo refuses the character; stored entries stay intact
    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            rx_wp   <= 4'h0;
            rx_rp   <= 4'h0;
            rx_cnt  <= 5'd0;
            ov_pend <= 1'b0;
        end else begin
            if (rx_wr) begin
                rx_wp <= rx_wp + 4'h1;
            end
            if (rx_pop) begin
                rx_rp <= rx_rp + 4'h1;
            end
            if (rx_wr & ~rx_pop) begin
                rx_cnt <= rx_cnt + 5'd1;
            end else if (rx_pop & ~rx_wr) begin
                rx_cnt <= rx_cnt - 5'd1;
            end
            if (overrun) begin
                ov_pend <= 1'b1;
            end else if (rx_wr) begin
                ov_pend <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // receive status: errors of the character just read, overrun live
    // ------------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            receive_error_status <= `URS_ERR_RST;
        end else begin
            if (access & pwrite_i & hit_err) begin
                receive_error_status <= `URS_ERR_RST;
            end else if (rx_pop) begin
                receive_error_status[2:0] <= rx_top[10:8];
            end
            // set wins over a clear in the same cycle
            if (overrun) begin
                receive_error_status[`URS_ERR_OE] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------------
    localparam R_IDLE  = 3'd0;
    localparam R_START = 3'd1;
    localparam R_DATA  = 3'd2;
    localparam R_PAR   = 3'd3;
    localparam R_STOP  = 3'd4;
    localparam R_BRK   = 3'd5;
    localparam R_WAIT  = 3'd6;

    reg  [2:0]  rx_state;
    reg  [19:0] rx_tmr;
    reg  [2:0]  rx_idx;
    reg  [7:0]  rx_data;
    reg         rx_par;
    reg         rx_prev;

    wire rx_en   = ctrl[`URS_CR_EN] & ctrl[`URS_CR_RXE];
    wire exp_par = sps ? ~eps : (eps ? ^rx_data : ~^rx_data);
    wire parerr  = pen & (rx_par != exp_par);

    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            rx_state <= R_IDLE;
            rx_tmr   <= 20'h00000;
            rx_idx   <= 3'h0;
            rx_data  <= 8'h00;
            rx_par   <= 1'b0;
            rx_prev  <= 1'b1;
            rx_push  <= 1'b0;
            rx_word  <= 12'h000;
        end else begin
            rx_prev <= rx_s;
            rx_push <= 1'b0;
            if (rx_tmr != 20'h00000 && rx_state != R_BRK) begin
                rx_tmr <= rx_tmr - 20'h00001;
            end else begin
                case (rx_state)
                    R_IDLE: begin
                        if (rx_en & rx_prev & ~rx_s) begin
                            rx_state <= R_START;
                            rx_tmr   <= half_len;
                            rx_data  <= 8'h00;
                        end
                    end
                    R_START: begin
                        // a glitch shorter than half a bit is no start
                        if (~rx_s) begin
                            rx_state <= R_DATA;
                            rx_tmr   <= bit_len - 20'h00001;
                            rx_idx   <= 3'h0;
                        end else begin
                            rx_state <= R_IDLE;
                        end
                    end
                    R_DATA: begin
                        rx_data[rx_idx] <= rx_s;
                        rx_tmr          <= bit_len - 20'h00001;
                        if ({1'b0, rx_idx} == nbits - 4'd1) begin
                            rx_state <= pen ? R_PAR : R_STOP;
                        end else begin
                            rx_idx <= rx_idx + 3'h1;
                        end
                    end
                    R_PAR: begin
                        rx_par   <= rx_s;
                        rx_tmr   <= bit_len - 20'h00001;
                        rx_state <= R_STOP;
                    end
                    R_STOP: begin
                        if (rx_s) begin
                            rx_push  <= 1'b1;
                            rx_word  <= {ov_pend, 1'b0, parerr, 1'b0, rx_data};
                            rx_state <= R_IDLE;
                        end else if (rx_data == 8'h00 &&
                                     (~pen || ~rx_par)) begin
                            // low since start: watch past the frame end
                            rx_state <= R_BRK;
                            rx_tmr   <= half_len;
                        end else begin
                            rx_push  <= 1'b1;
                            rx_word  <= {ov_pend, 1'b0, parerr, 1'b1, rx_data};
                            rx_state <= R_WAIT;
                        end
                    end
                    R_BRK: begin
                        if (rx_s) begin
                            rx_push  <= 1'b1;
                            rx_word  <= {ov_pend, 1'b0, parerr, 1'b1, rx_data};
                            rx_state <= R_IDLE;
                        end else if (rx_tmr == 20'h00000) begin
                            rx_push  <= 1'b1;
                            rx_word  <= {ov_pend, 1'b1, 2'b00, 8'h00};
                            rx_state <= R_WAIT;
                        end else begin
                            rx_tmr <= rx_tmr - 20'h00001;
                        end
                    end
                    R_WAIT: begin
                        if (rx_s) begin
                            rx_state <= R_IDLE;
                        end
                    end
                    default: begin
                        rx_state <= R_IDLE;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // transmit fifo and shifter
    // ------------------------------------------------------------------
    reg  [7:0]  tx_mem [0:15];
    reg  [3:0]  tx_wp;
    reg  [3:0]  tx_rp;
    reg  [4:0]  tx_cnt;
    reg         tx_active;
    reg  [19:0] tx_tmr;
    reg  [11:0] tx_sh;
    reg  [3:0]  tx_left;
    reg  [11:0] tx_rest;
    reg  [7:0]  tx_d;
    integer     i;

    wire tx_full  = (tx_cnt >= depth);
    wire tx_empty = (tx_cnt == 5'd0);
    wire tx_push  = access & pwrite_i & hit_data & ~tx_full;
    wire tx_load  = ~tx_active & ~tx_empty &
                    ctrl[`URS_CR_EN] & ctrl[`URS_CR_TXE];
    wire tx_par   = sps ? ~eps : (eps ? ^tx_d : ~^tx_d);
    wire [3:0] tx_bits = nbits + {3'b000, pen} + 4'd1 +
                         {3'b000, line_control[`URS_LC_STP2]};

    // data, parity and stop bits that follow the start bit, lsb first
    always @* begin
        tx_d    = 8'h00;
        tx_rest = 12'hFFF;
        for (i = 0; i < 8; i = i + 1) begin
            if (i < nbits) begin
                tx_d[i]    = tx_mem[tx_rp][i];
                tx_rest[i] = tx_mem[tx_rp][i];
            end
        end
        if (pen) begin
            tx_rest[nbits] = tx_par;
        end
    end

    always @(posedge clk_sys_i) begin
        if (tx_push) begin
            tx_mem[tx_wp] <= pwdata_i[7:0];
        end
    end

    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            tx_wp     <= 4'h0;
            tx_rp     <= 4'h0;
            tx_cnt    <= 5'd0;
            tx_active <= 1'b0;
            tx_tmr    <= 20'h00000;
            tx_sh     <= 12'hFFF;
            tx_left   <= 4'h0;
            tx_o      <= 1'b1;
        end else begin
            if (tx_push) begin
                tx_wp <= tx_wp + 4'h1;
            end
            if (tx_load) begin
                tx_rp <= tx_rp + 4'h1;
            end
            if (tx_push & ~tx_load) begin
                tx_cnt <= tx_cnt + 5'd1;
            end else if (tx_load & ~tx_push) begin
                tx_cnt <= tx_cnt - 5'd1;
            end
            if (tx_load) begin
                tx_active <= 1'b1;
                tx_o      <= 1'b0;
                tx_sh     <= tx_rest;
                tx_left   <= tx_bits;
                tx_tmr    <= bit_len - 20'h00001;
            end else if (tx_active) begin
                if (tx_tmr != 20'h00000) begin
                    tx_tmr <= tx_tmr - 20'h00001;
                end else if (tx_left == 4'h0) begin
                    tx_active <= 1'b0;
                end else begin
                    tx_o    <= tx_sh[0];
                    tx_sh   <= {1'b1, tx_sh[11:1]};
                    tx_left <= tx_left - 4'h1;
                    tx_tmr  <= bit_len - 20'h00001;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // flags and apb slave
    // ------------------------------------------------------------------
    wire [15:0] line_fifo_flags = {
        7'h00,
        ~ring_s,
        tx_empty,
        rx_full,
        tx_full,
        rx_empty,
        tx_active | ~tx_empty,
        ~carrier_s,
        ~peer_s,
        ~permit_s
    };

    // no wait state: data are formed in setup, taken in the access edge
    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            prdata_o     <= 32'h00000000;
            pready_o     <= 1'b0;
            pslverr_o    <= 1'b0;
            rd_ok        <= 1'b0;
            baud_div     <= `URS_BAUD_RST;
            line_control <= `URS_LC_RST;
            ctrl         <= `URS_CR_RST;
        end else begin
            pready_o  <= psel_i & ~penable_i;
            pslverr_o <= psel_i & ~penable_i & ~mapped;
            // the pop is kept to the word actually returned
            rd_ok     <= ~rx_empty;
            prdata_o  <= 32'h00000000;
            if (psel_i & ~penable_i & ~pwrite_i) begin
                if (hit_data) begin
                    prdata_o <= {20'h00000, rx_top};
                end else if (hit_err) begin
                    prdata_o <= {28'h0000000, receive_error_status};
                end else if (hit_flags) begin
                    prdata_o <= {16'h0000, line_fifo_flags};
                end else if (hit_baud) begin
                    prdata_o <= {16'h0000, baud_div};
                end else if (hit_line) begin
                    prdata_o <= {24'h000000, line_control};
                end else if (hit_ctrl) begin
                    prdata_o <= {16'h0000, ctrl};
                end
            end
            if (access & pwrite_i) begin
                if (hit_baud) begin
                    baud_div <= pwdata_i[15:0];
                end
                if (hit_line) begin
                    line_control <= pwdata_i[7:0];
                end
                if (hit_ctrl) begin
                    ctrl <= pwdata_i[15:0];
                end
            end
        end
    end

endmodule // urs_top

// ==== sim/urs_sva.sv ====
// port assertions for the serial status block
module urs_sva (
    input wire logic        clk_sys_i,
    input wire logic        sys_rst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        rx_i,
    input wire logic        tx_o,
    input wire logic        ring_in_n_i,
    input wire logic        carrier_in_n_i,
    input wire logic        peer_ready_in_n_i,
    input wire logic        send_permit_in_n_i
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    wire rd_flags = pready_o && !pwrite_i && paddr_i == 12'h018;
    wire rd_err = pready_o && !pwrite_i && paddr_i == 12'h004;
    property p_rdy_cause;
        pready_o |-> $past(psel_i && !penable_i);
    endproperty
    a_rdy_cause: assert property (p_rdy_cause) else $error("stray ready");
    property p_rdy_next;
        psel_i && !penable_i |=> pready_o;
    endproperty
    a_rdy_next: assert property (p_rdy_next) else $error("ready late");
    property p_rdy_pulse;
        pready_o |=> !pready_o;
    endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready held");
    property p_rdata_zero;
        !pready_o |-> prdata_o == 32'h0;
    endproperty
    a_rdata_zero: assert property (p_rdata_zero) else $error("data idle");
    property p_slverr;
        pready_o && paddr_i inside {[12'h008:12'h014]} |-> pslverr_o;
    endproperty
    a_slverr: assert property (p_slverr) else $error("no slave error");
    property p_flag_rsvd;
        rd_flags |-> prdata_o[15:9] == 7'h00;
    endproperty
    a_flag_rsvd: assert property (p_flag_rsvd) else $error("flag rsvd");
    // a clear followed by a status read must see no error of bits 2:0
    property p_clear;
        pready_o && pwrite_i && paddr_i == 12'h004 ##2 psel_i && !penable_i
        && !pwrite_i && paddr_i == 12'h004 |=> prdata_o[2:0] == 3'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("clear lost");
    property p_modem;
        $stable({ring_in_n_i, carrier_in_n_i, peer_ready_in_n_i,
                 send_permit_in_n_i})[*6] ##1 rd_flags |-> prdata_o[8] ==
        !ring_in_n_i && prdata_o[2:0] == ~{carrier_in_n_i,
        peer_ready_in_n_i, send_permit_in_n_i};
    endproperty
    a_modem: assert property (p_modem) else $error("modem flags");
    property p_busy;
        rd_flags && !tx_o && $past(!tx_o) |-> prdata_o[3];
    endproperty
    a_busy: assert property (p_busy) else $error("busy low in frame");
    c_clear: cover property (pready_o && pwrite_i && paddr_i == 12'h004);
    c_busy: cover property (rd_flags && prdata_o[3]);
    c_err: cover property (rd_err && prdata_o[3:0] != 4'h0);
endmodule // urs_sva

bind urs_top urs_sva i_urs_sva (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .rx_i(rx_i), .tx_o(tx_o),
    .ring_in_n_i(ring_in_n_i), .carrier_in_n_i(carrier_in_n_i),
    .peer_ready_in_n_i(peer_ready_in_n_i),
    .send_permit_in_n_i(send_permit_in_n_i));

// ==== sim/urs_peer.sv ====
// remote terminal model driving the serial input and modem pins
module urs_peer (
    input  wire logic       clk_sys_i,
    output logic            rx_o,
    output logic [3:0]      modem_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // modem_n_o is {ring, carrier, peer_ready, send_permit}, active low
    initial begin
        rx_o = 1'b1;
        modem_n_o = 4'hF;
    end
    task automatic set_modem(input logic [3:0] v);
        modem_n_o <= v;
    endtask
    // bit time fixed at 16 clocks, matching a divisor of 1
    task automatic hold_bit(input logic v, input int n);
        rx_o <= v;
        repeat (n * 16) @(posedge clk_sys_i);
    endtask
    // 8 data bits lsb first, even parity unless told to break it
    task automatic send_char(input logic [7:0] d, input logic bad,
                             input logic par, input logic stop);
        hold_bit(1'b0, 1);
        for (int i = 0; i < 8; i++) hold_bit(d[i], 1);
        if (par) hold_bit(^d ^ bad, 1);
        hold_bit(stop, 1);
        hold_bit(1'b1, 2);
    endtask
endmodule // urs_peer

// ==== sim/uart_rx_status_and_flags_test.sv ====
// self-checking bench for the serial status block
`include "urs_defines.vh"
module uart_rx_status_and_flags_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic        rx_i;
    logic        tx_o;
    logic [3:0]  modem_n;
    logic [31:0] rd;
    logic        err;
    int          num_errors = 0;
    int          n_tests = 0;
    initial forever #12.5 clk_sys_i = ~clk_sys_i;
    urs_top i_urs_top (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_i(rx_i),
        .tx_o(tx_o), .ring_in_n_i(modem_n[3]), .carrier_in_n_i(modem_n[2]),
        .peer_ready_in_n_i(modem_n[1]), .send_permit_in_n_i(modem_n[0]));
    urs_peer i_urs_peer (.clk_sys_i(clk_sys_i), .rx_o(rx_i),
        .modem_n_o(modem_n));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one transfer; the wait is bounded so a dead slave cannot hang us
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk_sys_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        rd = prdata_o;
        err = pslverr_o;
        if (n >= 50) check(32'h0, 32'h1);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(a == `URS_OFS_ERR ? rd & ~32'hF0 : rd, exp);
    endtask
    task automatic cfg(input logic [31:0] line);
        apb(1'b1, `URS_OFS_BAUD, 32'h1);
        apb(1'b1, `URS_OFS_LINE, line);
        apb(1'b1, `URS_OFS_CTRL, 32'h301);
    endtask
    task automatic t_reset;
        rd_chk(`URS_OFS_FLAGS, 32'h90);
        rd_chk(`URS_OFS_ERR, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        check({31'h0, err}, 32'h1);
    endtask
    task automatic t_modem;
        for (int i = 0; i < 4; i++) begin
            i_urs_peer.set_modem(~(4'h1 << i));
            repeat (8) @(posedge clk_sys_i);
            rd_chk(`URS_OFS_FLAGS, 32'h90 | (i == 3 ? 32'h100 : 1 << i));
        end
        i_urs_peer.set_modem(4'hF);
        repeat (8) @(posedge clk_sys_i);
    endtask
    task automatic t_errors;
        cfg(32'h76);
        i_urs_peer.send_char(8'hA5, 1'b0, 1'b1, 1'b1);
        i_urs_peer.send_char(8'h3C, 1'b1, 1'b1, 1'b1);
        i_urs_peer.send_char(8'h81, 1'b0, 1'b1, 1'b0);
        rd_chk(`URS_OFS_DATA, 32'h0A5);
        rd_chk(`URS_OFS_DATA, 32'h23C);
        rd_chk(`URS_OFS_ERR, 32'h2);
        rd_chk(`URS_OFS_ERR, 32'h2);
        rd_chk(`URS_OFS_DATA, 32'h181);
        rd_chk(`URS_OFS_ERR, 32'h1);
        apb(1'b1, `URS_OFS_ERR, 32'hFF);
        rd_chk(`URS_OFS_ERR, 32'h0);
        cfg(32'hF6);
        i_urs_peer.send_char(8'h01, 1'b0, 1'b1, 1'b1);
        rd_chk(`URS_OFS_DATA, 32'h201);
    endtask
    task automatic t_break;
        i_urs_peer.hold_bit(1'b0, 12);
        i_urs_peer.hold_bit(1'b1, 2);
        i_urs_peer.send_char(8'h5A, 1'b0, 1'b1, 1'b1);
        rd_chk(`URS_OFS_DATA, 32'h400);
        rd_chk(`URS_OFS_ERR, 32'h4);
        rd_chk(`URS_OFS_DATA, 32'h05A);
        rd_chk(`URS_OFS_FLAGS, 32'h90);
        apb(1'b1, `URS_OFS_ERR, 32'h0);
    endtask
    task automatic t_overrun;
        cfg(32'h60);
        i_urs_peer.send_char(8'h11, 1'b0, 1'b0, 1'b1);
        rd_chk(`URS_OFS_FLAGS, 32'hC0);
        i_urs_peer.send_char(8'h22, 1'b0, 1'b0, 1'b1);
        rd_chk(`URS_OFS_ERR, 32'h8);
        rd_chk(`URS_OFS_DATA, 32'h011);
        rd_chk(`URS_OFS_FLAGS, 32'h90);
        apb(1'b1, `URS_OFS_ERR, 32'h0);
        rd_chk(`URS_OFS_ERR, 32'h0);
    endtask
    task automatic t_tx;
        apb(1'b1, `URS_OFS_CTRL, 32'h0);
        apb(1'b1, `URS_OFS_LINE, 32'h70);
        apb(1'b1, `URS_OFS_DATA, 32'h0);
        rd_chk(`URS_OFS_FLAGS, 32'h18);
        repeat (15) apb(1'b1, `URS_OFS_DATA, 32'h5A);
        rd_chk(`URS_OFS_FLAGS, 32'h38);
        apb(1'b1, `URS_OFS_CTRL, 32'h301);
        repeat (2) @(posedge clk_sys_i);
        check({31'h0, tx_o}, 32'h0);
        for (int n = 0; n < 2000 && rd[7] !== 1'b1; n++)
            apb(1'b0, `URS_OFS_FLAGS, 32'h0);
        check(rd & 32'h88, 32'h88);
        for (int n = 0; n < 200 && rd[3] !== 1'b0; n++)
            apb(1'b0, `URS_OFS_FLAGS, 32'h0);
        check(rd, 32'h90);
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_modem();
        t_errors();
        t_break();
        t_overrun();
        t_tx();
        finish_test();
    end
    // whole run needs under 10k clocks
    initial begin
        #500000;
        num_errors++;
        finish_test();
    end
endmodule // uart_rx_status_and_flags_test
